// ==== pkg/mmu_consts.svh ====
// Constants for the translation unit: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef MMU_CONSTS_SVH
`define MMU_CONSTS_SVH
`define MMU_MAIN_ENTRIES 64
`define MMU_ISHADOW_ENTRIES 4
`define MMU_DSHADOW_ENTRIES 8
`define MMU_REG_MACHINE_STATE 6'h00
`define MMU_REG_ZONE_PROT 6'h01
`define MMU_REG_RATTR_W 6'h02
`define MMU_REG_RATTR_I 6'h03
`define MMU_REG_RATTR_UDEF 6'h04
`define MMU_REG_RATTR_G 6'h05
`define MMU_REG_RATTR_E 6'h06
`define MMU_REG_IDX 6'h07
`define MMU_REG_HI 6'h08
`define MMU_REG_LO 6'h09
`define MMU_REG_CMD 6'h0a
`define MMU_REG_STAT 6'h0b
`define MMU_REG_MASK 6'h0c
`define MMU_MODE_USER_BIT 0
`define MMU_MODE_ITRANS_BIT 1
`define MMU_MODE_DTRANS_BIT 2
`define MMU_CMD_WRITE_BIT 0
`define MMU_CMD_READ_BIT 1
`define MMU_CMD_INVAL_BIT 2
`define MMU_HI_VALID_BIT 9
`define MMU_HI_SIZE_LSB 6
`define MMU_LO_EXEC_BIT 9
`define MMU_LO_WR_BIT 8
`define MMU_LO_ZONE_LSB 4
`define MMU_LO_ATTR_LSB 0
`define MMU_ST_IMISS_BIT 0
`define MMU_ST_DMISS_BIT 1
`define MMU_ST_IPROT_BIT 2
`define MMU_ST_DPROT_BIT 3
`define MMU_ST_PRIV_BIT 4
`define MMU_RST_WORD 32'h0000_0000
`endif

// ==== pkg/mmu_pkg.sv ====
// Types shared by the translation unit and its shadow arrays.
// Assumes the constants header is on the include path.
`include "mmu_consts.svh"
package mmu_pkg;
  typedef struct packed {
    logic valid;
    logic [2:0] size;
    logic [21:0] epn;
    logic [21:0] rpn;
    logic execute_permit;
    logic wr;
    logic [3:0] zone;
    logic [5:0] attr;
  } tlb_entry_type;

  typedef enum logic [1:0] {
    zone_deny_type_q,
    zone_entry_type_q,
    zone_widen_type_q,
    zone_user_entry_type_q
  } zone_mode_type;

  // Page mask: size 0 is 1KB, each step multiplies by four
  function automatic logic [21:0] page_mask(input logic [2:0] size);
    logic [21:0] m;
    m = 22'h3fffff;
    m = m << (size * 2);
    return m;
  endfunction : page_mask

  function automatic logic page_hit(input tlb_entry_type e, input logic [31:0] la);
    logic [21:0] m;
    m = page_mask(e.size);
    return e.valid && ((la[31:10] & m) == (e.epn & m));
  endfunction : page_hit

  function automatic logic [31:0] page_xlate(input tlb_entry_type e, input logic [31:0] la);
    logic [21:0] m;
    m = page_mask(e.size);
    return {(e.rpn & m) | (la[31:10] & ~m), la[9:0]};
  endfunction : page_xlate
endpackage : mmu_pkg

// ==== logic/mmu_shadow.sv ====
// Small fully associative shadow array filled from the main buffer.
// Assumes the parent flushes it whenever a main entry changes.
module mmu_shadow #(
  parameter int DEPTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_flush,
  input wire logic [31:0] i_addr,
  input wire logic i_fill,
  input wire mmu_pkg::tlb_entry_type i_fill_entry,
  output logic o_hit,
  output mmu_pkg::tlb_entry_type o_entry
);
  import mmu_pkg::*;
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  tlb_entry_type ent_q [DEPTH];
  logic [IW-1:0] victim_q;

  always_comb
  begin
    o_hit = 1'b0;
    o_entry = '0;
    for (int k = 0; k < DEPTH; k++)
    begin
      if (!o_hit && page_hit(ent_q[k], i_addr))
      begin
        o_hit = 1'b1;
        o_entry = ent_q[k];
      end
    end
  end

  // Round robin replacement; hardware only
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || i_flush)
    begin
      for (int k = 0; k < DEPTH; k++)
        ent_q[k] <= '0;
      victim_q <= '0;
    end
    else if (i_fill)
    begin
      ent_q[victim_q] <= i_fill_entry;
      victim_q <= (victim_q == IW'(DEPTH - 1)) ? '0 : victim_q + 1'b1;
    end
  end
endmodule : mmu_shadow

// ==== logic/mmu_xlate.sv ====
// Translation and protection unit with 64-entry main buffer and two shadow arrays.
// Assumes a pipeline that holds each request until it is answered.
// Overview of operation
// - Main buffer has 64 fully associative entries, all compared each lookup.
// - Each entry has one of eight page sizes, 1KB to 16MB, mixed.
// - Translated access without a covering valid entry raises a miss.
// - Four instruction and eight data shadow entries back onto the main buffer.
// - Shadow entries are filled, replaced and invalidated by hardware only.
// - With translation on, unmapped locations are never accessed.
// - Valid entry grants read; execute and write bits grant fetch and store.
// - Zone register overrides entry permissions, including user read denial.
// - With translation on, entry attribute bits give the storage attributes.
// - Translation off: per-128MB-region attribute registers give the attributes.
// - Instruction and data translation have separate enable bits.
// - Data translated before cache; fetches use logical index, physical tag.
// - Entry fields can be copied to and from general registers.
// - Full 32-bit logical space maps to physical addresses.
// - Six attributes per translated access, five per untranslated one, go to cache and bus logic.
`include "mmu_consts.svh"
module mmu_xlate #(
  parameter int ENTRIES = `MMU_MAIN_ENTRIES,
  parameter int IDEPTH = `MMU_ISHADOW_ENTRIES,
  parameter int DDEPTH = `MMU_DSHADOW_ENTRIES
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [5:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_if_req,
  input wire logic [31:0] i_if_addr,
  output logic o_if_done,
  output logic [31:0] o_if_paddr,
  output logic [9:0] o_if_index,
  output logic [5:0] o_if_attr,
  output logic o_if_miss,
  output logic o_if_prot,
  input wire logic i_ls_req,
  input wire logic i_ls_store,
  input wire logic [31:0] i_ls_addr,
  output logic o_ls_done,
  output logic [31:0] o_ls_paddr,
  output logic [5:0] o_ls_attr,
  output logic o_ls_miss,
  output logic o_ls_prot,
  output logic o_irq
);
  import mmu_pkg::*;

  tlb_entry_type main_q [ENTRIES];
  logic [31:0] machine_state_reg_q;
  logic [31:0] zone_protection_reg_q;
  logic [31:0] rattr_q [5];
  logic [5:0] idx_q;
  logic [31:0] hi_q;
  logic [31:0] lo_q;
  logic [4:0] stat_q;
  logic [4:0] mask_q;
  logic flush;
  logic priv_err;
  logic [4:0] ev;

  wire logic user_mode = machine_state_reg_q[`MMU_MODE_USER_BIT];
  wire logic instr_translate_enable = machine_state_reg_q[`MMU_MODE_ITRANS_BIT];
  wire logic data_translate_enable = machine_state_reg_q[`MMU_MODE_DTRANS_BIT];
  wire logic cmd_wr = i_reg_wr && (i_reg_addr == `MMU_REG_CMD);

  // Full compare of every slot; lowest index wins on overlap
  function automatic logic main_lookup(input logic [31:0] la, output tlb_entry_type e);
    logic h;
    h = 1'b0;
    e = '0;
    for (int k = 0; k < ENTRIES; k++)
    begin
      if (!h && page_hit(main_q[k], la))
      begin
        h = 1'b1;
        e = main_q[k];
      end
    end
    return h;
  endfunction : main_lookup

  // Zone field decides whether entry rights apply, widen or deny
  function automatic logic allowed(input tlb_entry_type e, input logic want_x,
      input logic want_w);
    logic [1:0] z;
    logic rx;
    logic rw;
    z = zone_protection_reg_q[31 - 2 * e.zone -: 2];
    rx = e.execute_permit;
    rw = e.wr;
    allowed = 1'b1;
    unique case (z)
      2'b00: allowed = !user_mode;
      2'b01: ;
      2'b10:
      begin
        if (!user_mode)
        begin
          rx = 1'b1;
          rw = 1'b1;
        end
      end
      2'b11:
      begin
        rx = 1'b1;
        rw = 1'b1;
      end
    endcase
    if (want_x && !rx)
      allowed = 1'b0;
    if (want_w && !rw)
      allowed = 1'b0;
  endfunction : allowed

  function automatic logic [5:0] real_attr(input logic [31:0] pa);
    logic [5:0] a;
    a = '0;
    for (int k = 0; k < 5; k++)
      a[k] = rattr_q[k][31 - pa[31:27]];
    return a;
  endfunction : real_attr

  // Instruction side: shadow first, main buffer on shadow miss
  logic ish_hit;
  tlb_entry_type ish_e;
  tlb_entry_type if_main_e;
  logic if_main_hit;
  logic if_fill;

  mmu_shadow #(.DEPTH(IDEPTH)) u_ishadow (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_flush(flush),
    .i_addr(i_if_addr),
    .i_fill(if_fill),
    .i_fill_entry(if_main_e),
    .o_hit(ish_hit),
    .o_entry(ish_e)
  );

  logic dsh_hit;
  tlb_entry_type dsh_e;
  tlb_entry_type ls_main_e;
  logic ls_main_hit;
  logic ls_fill;

  mmu_shadow #(.DEPTH(DDEPTH)) u_dshadow (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_flush(flush),
    .i_addr(i_ls_addr),
    .i_fill(ls_fill),
    .i_fill_entry(ls_main_e),
    .o_hit(dsh_hit),
    .o_entry(dsh_e)
  );

  always_comb
  begin
    if_main_hit = main_lookup(i_if_addr, if_main_e);
    ls_main_hit = main_lookup(i_ls_addr, ls_main_e);
  end

  // A shadow miss that hits the main buffer costs one cycle: fill, then answer from the shadow
  assign if_fill = i_if_req && instr_translate_enable && !ish_hit && if_main_hit && !flush;
  assign ls_fill = i_ls_req && data_translate_enable && !dsh_hit && ls_main_hit && !flush;

  logic if_take;
  logic ls_take;
  assign if_take = i_if_req && (!instr_translate_enable || ish_hit || !if_main_hit) && !flush;
  assign ls_take = i_ls_req && (!data_translate_enable || dsh_hit || !ls_main_hit) && !flush;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_if_done <= 1'b0;
      o_if_paddr <= '0;
      o_if_index <= '0;
      o_if_attr <= '0;
      o_if_miss <= 1'b0;
      o_if_prot <= 1'b0;
    end
    else
    begin
      o_if_done <= if_take;
      o_if_miss <= 1'b0;
      o_if_prot <= 1'b0;
      if (if_take)
      begin
        o_if_index <= i_if_addr[9:0];
        if (!instr_translate_enable)
        begin
          o_if_paddr <= i_if_addr;
          o_if_attr <= real_attr(i_if_addr);
        end
        else if (!ish_hit)
        begin
          o_if_miss <= 1'b1;
          o_if_paddr <= '0;
          o_if_attr <= '0;
        end
        else
        begin
          o_if_paddr <= page_xlate(ish_e, i_if_addr);
          o_if_attr <= ish_e.attr;
          o_if_prot <= !allowed(ish_e, 1'b1, 1'b0);
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_ls_done <= 1'b0;
      o_ls_paddr <= '0;
      o_ls_attr <= '0;
      o_ls_miss <= 1'b0;
      o_ls_prot <= 1'b0;
    end
    else
    begin
      o_ls_done <= ls_take;
      o_ls_miss <= 1'b0;
      o_ls_prot <= 1'b0;
      if (ls_take)
      begin
        if (!data_translate_enable)
        begin
          o_ls_paddr <= i_ls_addr;
          o_ls_attr <= real_attr(i_ls_addr);
        end
        else if (!dsh_hit)
        begin
          o_ls_miss <= 1'b1;
          o_ls_paddr <= '0;
          o_ls_attr <= '0;
        end
        else
        begin
          o_ls_paddr <= page_xlate(dsh_e, i_ls_addr);
          o_ls_attr <= dsh_e.attr;
          o_ls_prot <= !allowed(dsh_e, 1'b0, i_ls_store);
        end
      end
    end
  end

  // Entry management commands; user mode attempts are refused and flagged
  assign priv_err = cmd_wr && user_mode && (i_reg_wdata[2:0] != 3'h0);
  assign flush = cmd_wr && !user_mode
    && (i_reg_wdata[`MMU_CMD_WRITE_BIT] || i_reg_wdata[`MMU_CMD_INVAL_BIT]);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      for (int k = 0; k < ENTRIES; k++)
        main_q[k] <= '0;
    end
    else if (cmd_wr && !user_mode)
    begin
      // Slot is whatever software put in the index register
      if (i_reg_wdata[`MMU_CMD_WRITE_BIT])
      begin
        main_q[idx_q] <= '{valid: hi_q[`MMU_HI_VALID_BIT], size: hi_q[8:6],
          epn: hi_q[31:10], rpn: lo_q[31:10], execute_permit: lo_q[`MMU_LO_EXEC_BIT],
          wr: lo_q[`MMU_LO_WR_BIT], zone: lo_q[7:4], attr: lo_q[5:0]};
      end
      else if (i_reg_wdata[`MMU_CMD_INVAL_BIT])
        main_q[idx_q].valid <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      machine_state_reg_q <= `MMU_RST_WORD;
      zone_protection_reg_q <= `MMU_RST_WORD;
      for (int k = 0; k < 5; k++)
        rattr_q[k] <= `MMU_RST_WORD;
      idx_q <= '0;
      hi_q <= `MMU_RST_WORD;
      lo_q <= `MMU_RST_WORD;
      mask_q <= '0;
    end
    else if (cmd_wr && !user_mode && i_reg_wdata[`MMU_CMD_READ_BIT])
    begin
      hi_q <= {main_q[idx_q].epn, main_q[idx_q].valid, main_q[idx_q].size, 6'h00};
      // Zone and attribute share bits 5:4, so the zone supplies them
      lo_q <= {main_q[idx_q].rpn, main_q[idx_q].execute_permit, main_q[idx_q].wr,
        main_q[idx_q].zone, main_q[idx_q].attr[3:0]};
    end
    else if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        `MMU_REG_MACHINE_STATE: machine_state_reg_q <= i_reg_wdata;
        `MMU_REG_ZONE_PROT: zone_protection_reg_q <= i_reg_wdata;
        `MMU_REG_RATTR_W: rattr_q[0] <= i_reg_wdata;
        `MMU_REG_RATTR_I: rattr_q[1] <= i_reg_wdata;
        `MMU_REG_RATTR_UDEF: rattr_q[2] <= i_reg_wdata;
        `MMU_REG_RATTR_G: rattr_q[3] <= i_reg_wdata;
        `MMU_REG_RATTR_E: rattr_q[4] <= i_reg_wdata;
        `MMU_REG_IDX: idx_q <= i_reg_wdata[5:0];
        `MMU_REG_HI: hi_q <= i_reg_wdata;
        `MMU_REG_LO: lo_q <= i_reg_wdata;
        `MMU_REG_MASK: mask_q <= i_reg_wdata[4:0];
        default: ;
      endcase
    end
  end

  // Events set sticky bits; a read clears, but a same-cycle event survives
  assign ev = {priv_err, o_ls_prot, o_if_prot, o_ls_miss, o_if_miss};
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      stat_q <= '0;
    else if (i_reg_rd && i_reg_addr == `MMU_REG_STAT)
      stat_q <= ev;
    else
      stat_q <= stat_q | ev;
  end

  assign o_irq = |(stat_q & mask_q);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_reg_rdata <= '0;
    else if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        `MMU_REG_MACHINE_STATE: o_reg_rdata <= machine_state_reg_q;
        `MMU_REG_ZONE_PROT: o_reg_rdata <= zone_protection_reg_q;
        `MMU_REG_RATTR_W: o_reg_rdata <= rattr_q[0];
        `MMU_REG_RATTR_I: o_reg_rdata <= rattr_q[1];
        `MMU_REG_RATTR_UDEF: o_reg_rdata <= rattr_q[2];
        `MMU_REG_RATTR_G: o_reg_rdata <= rattr_q[3];
        `MMU_REG_RATTR_E: o_reg_rdata <= rattr_q[4];
        `MMU_REG_IDX: o_reg_rdata <= {26'h0, idx_q};
        `MMU_REG_HI: o_reg_rdata <= hi_q;
        `MMU_REG_LO: o_reg_rdata <= lo_q;
        `MMU_REG_STAT: o_reg_rdata <= {27'h0, stat_q};
        `MMU_REG_MASK: o_reg_rdata <= {27'h0, mask_q};
        default: o_reg_rdata <= '0;
      endcase
    end
    else
      o_reg_rdata <= '0;
  end
endmodule : mmu_xlate

// ==== verif/xlate_monitor.sv ====
// Checker on the translation unit ports.
// Assumes one clock domain and binding to mmu_xlate.
module xlate_monitor (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic i_if_req,
  input wire logic [31:0] i_if_addr,
  input wire logic o_if_done,
  input wire logic [31:0] o_if_paddr,
  input wire logic [9:0] o_if_index,
  input wire logic o_if_miss,
  input wire logic i_ls_req,
  input wire logic [31:0] i_ls_addr,
  input wire logic o_ls_done,
  input wire logic [31:0] o_ls_paddr,
  input wire logic o_ls_miss,
  input wire logic o_ls_prot,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_if_cause: assert property (o_if_done |-> $past(i_if_req))
    else $error("fetch answer without request");
  a_ls_cause: assert property (o_ls_done |-> $past(i_ls_req))
    else $error("data answer without request");
  a_if_answer: assert property ($rose(i_if_req) |-> ##[1:4] o_if_done)
    else $error("fetch answer late");
  a_miss_paddr: assert property (o_if_miss |-> o_if_done && o_if_paddr == 32'h0)
    else $error("fetch miss leaks an address");
  a_ls_miss_zero: assert property (o_ls_miss |-> o_ls_paddr == 32'h0)
    else $error("data miss leaks an address");
  a_ls_flags: assert property ((o_ls_miss || o_ls_prot) |-> o_ls_done)
    else $error("data flag without answer");
  a_fetch_index: assert property (o_if_done |-> o_if_index == $past(i_if_addr[9:0]))
    else $error("fetch index not logical");
  a_if_offset: assert property (o_if_done && !o_if_miss
    |-> o_if_paddr[9:0] == $past(i_if_addr[9:0]))
    else $error("fetch page offset changed");
  a_ls_offset: assert property (o_ls_done && !o_ls_miss
    |-> o_ls_paddr[9:0] == $past(i_ls_addr[9:0]))
    else $error("data page offset changed");
  c_if_miss: cover property (o_if_miss);
  c_ls_prot: cover property (o_ls_prot);
  c_irq: cover property (o_irq);
endmodule : xlate_monitor

bind mmu_xlate xlate_monitor u_mon (.i_sys_clk, .i_srst, .i_reg_rd, .o_reg_rdata,
  .i_if_req, .i_if_addr, .o_if_done, .o_if_paddr, .o_if_index, .o_if_miss,
  .i_ls_req, .i_ls_addr, .o_ls_done, .o_ls_paddr, .o_ls_miss, .o_ls_prot, .o_irq);

// ==== verif/pipe_requester.sv ====
// Requester model for one translate port.
// Assumes the bench pulses i_go only while idle.
module pipe_requester (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_go,
  input wire logic [31:0] i_addr,
  input wire logic i_store,
  input wire logic i_done,
  output logic o_req,
  output logic [31:0] o_addr,
  output logic o_store
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy_q;
  // Drop in the answer cycle, else the unit takes it again
  assign o_req = busy_q && !i_done;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      busy_q <= 1'b0;
      o_addr <= 32'h0;
      o_store <= 1'b0;
    end
    else if (i_go)
    begin
      busy_q <= 1'b1;
      o_addr <= i_addr;
      o_store <= i_store;
    end
    else if (busy_q && i_done)
    begin
      busy_q <= 1'b0;
      // Released lines keep no stale value
      o_addr <= ~o_addr;
      o_store <= ~o_store;
    end
  end
endmodule : pipe_requester

// ==== verif/testbench.sv ====
// Self-checking bench for the translation unit.
// Assumes the design, requester model and checker are compiled with it.
`include "mmu_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] ra = 6'h0;
  logic [31:0] wd = 32'h0;
  logic rw = 1'b0;
  logic rr = 1'b0;
  logic gi = 1'b0;
  logic gd = 1'b0;
  logic [31:0] ga = 32'h0;
  logic gs = 1'b0;
  logic if_req, ls_req, ls_st, if_done, if_miss, if_prot, ls_done, ls_miss, ls_prot, irq;
  logic ifs_unused;
  logic [31:0] if_a, ls_a, rdata, if_pa, ls_pa;
  logic [9:0] if_ix;
  logic [5:0] if_at, ls_at;
  int miscompares = 0;
  int samples_checked = 0;
  mmu_xlate u_dut (.i_sys_clk(clk), .i_srst(srst), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_wr(rw), .i_reg_rd(rr), .o_reg_rdata(rdata), .i_if_req(if_req),
    .i_if_addr(if_a), .o_if_done(if_done), .o_if_paddr(if_pa), .o_if_index(if_ix),
    .o_if_attr(if_at), .o_if_miss(if_miss), .o_if_prot(if_prot), .i_ls_req(ls_req),
    .i_ls_store(ls_st), .i_ls_addr(ls_a), .o_ls_done(ls_done), .o_ls_paddr(ls_pa),
    .o_ls_attr(ls_at), .o_ls_miss(ls_miss), .o_ls_prot(ls_prot), .o_irq(irq));
  pipe_requester u_ifm (.i_sys_clk(clk), .i_srst(srst), .i_go(gi), .i_addr(ga),
    .i_store(gs), .i_done(if_done), .o_req(if_req), .o_addr(if_a), .o_store(ifs_unused));
  pipe_requester u_lsm (.i_sys_clk(clk), .i_srst(srst), .i_go(gd), .i_addr(ga),
    .i_store(gs), .i_done(ls_done), .o_req(ls_req), .o_addr(ls_a), .o_store(ls_st));
  task automatic close_out();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge clk);
    rw <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    ra <= a;
    rr <= 1'b1;
    @(posedge clk);
    rr <= 1'b0;
    #1;
    chk("reg", rdata, e);
  endtask : rd
  task automatic ent(input logic [31:0] i, input logic [31:0] h, input logic [31:0] l);
    wr(`MMU_REG_IDX, i);
    wr(`MMU_REG_HI, h);
    wr(`MMU_REG_LO, l);
    wr(`MMU_REG_CMD, 32'h1);
  endtask : ent
  // Flags are {miss, prot}; attributes are not judged on a miss
  task automatic xl(input logic s, input logic [31:0] a, input logic st,
    input logic [31:0] ep, input logic [5:0] ea, input logic [1:0] ef);
    int n;
    @(posedge clk);
    ga <= a;
    gs <= st;
    gd <= s;
    gi <= !s;
    @(posedge clk);
    gi <= 1'b0;
    gd <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while ((s ? ls_done : if_done) !== 1'b1 && n < 8);
    chk("done", {31'h0, s ? ls_done : if_done}, 32'h1);
    chk("paddr", s ? ls_pa : if_pa, ep);
    if (!ef[1])
      chk("attr", {26'h0, s ? ls_at : if_at}, {26'h0, ea});
    chk("flags", {30'h0, s ? {ls_miss, ls_prot} : {if_miss, if_prot}}, {30'h0, ef});
    if (!s)
      chk("index", {22'h0, if_ix}, {22'h0, a[9:0]});
  endtask : xl
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #200000;
    miscompares++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(`MMU_REG_MACHINE_STATE, 32'h0);
    rd(6'h3f, 32'h0);
    wr(`MMU_REG_RATTR_W, 32'h8000_0000);
    wr(`MMU_REG_RATTR_I, 32'h0000_0001);
    xl(0, 32'h0000_1234, 0, 32'h0000_1234, 6'h01, 2'b00);
    xl(1, 32'hf800_0010, 0, 32'hf800_0010, 6'h02, 2'b00);
    wr(`MMU_REG_MACHINE_STATE, 32'h2);
    xl(0, 32'h1234_5678, 0, 32'h0, 6'h0, 2'b10);
    xl(1, 32'h1234_5678, 0, 32'h1234_5678, 6'h00, 2'b00);
    rd(`MMU_REG_STAT, 32'h1);
    wr(`MMU_REG_ZONE_PROT, 32'h1000_0000);
    ent(32'd5, 32'h1234_5240, 32'habcd_e215);
    ent(32'd63, 32'h8000_03c0, 32'h4000_0300);
    wr(`MMU_REG_MACHINE_STATE, 32'h6);
    xl(0, 32'h1234_5678, 0, 32'habcd_e678, 6'h15, 2'b00);
    xl(0, 32'h1234_5ffc, 0, 32'habcd_effc, 6'h15, 2'b00);
    xl(1, 32'h1234_5678, 1, 32'habcd_e678, 6'h15, 2'b01);
    xl(1, 32'h1234_5678, 0, 32'habcd_e678, 6'h15, 2'b00);
    xl(1, 32'h80ab_cdef, 1, 32'h40ab_cdef, 6'h00, 2'b00);
    wr(`MMU_REG_HI, 32'h0);
    wr(`MMU_REG_LO, 32'h0);
    wr(`MMU_REG_IDX, 32'd5);
    wr(`MMU_REG_CMD, 32'h2);
    rd(`MMU_REG_HI, 32'h1234_5240);
    rd(`MMU_REG_LO, 32'habcd_e215);
    rd(`MMU_REG_STAT, 32'h8);
    wr(`MMU_REG_ZONE_PROT, 32'h0);
    wr(`MMU_REG_MACHINE_STATE, 32'h7);
    xl(1, 32'h1234_5678, 0, 32'habcd_e678, 6'h15, 2'b01);
    rd(`MMU_REG_STAT, 32'h8);
    wr(`MMU_REG_CMD, 32'h4);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(`MMU_REG_MASK, 32'h10);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(`MMU_REG_STAT, 32'h10);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(`MMU_REG_MACHINE_STATE, 32'h6);
    xl(0, 32'h1234_5678, 0, 32'habcd_e678, 6'h15, 2'b00);
    wr(`MMU_REG_CMD, 32'h4);
    xl(0, 32'h1234_5678, 0, 32'h0, 6'h0, 2'b10);
    xl(1, 32'h1234_5678, 0, 32'h0, 6'h0, 2'b10);
    xl(1, 32'h80ab_cdef, 0, 32'h40ab_cdef, 6'h00, 2'b00);
    close_out();
  end
endmodule : testbench
